// [hdl/esrb_defines.vh]
// Constants for the embedded synchronous RAM block
`ifndef ESRB_DEFINES_VH
`define ESRB_DEFINES_VH

// Variant codes
`define ESRB_VAR_SMALL  2'h0
`define ESRB_VAR_MEDIUM 2'h1
`define ESRB_VAR_LARGE  2'h2

// Port mode codes
`define ESRB_MODE_SINGLE 2'h0
`define ESRB_MODE_SIMPLE 2'h1
`define ESRB_MODE_TRUE   2'h2
`define ESRB_MODE_ROM    2'h3

// Maximum organisations per variant (words x bits)
`define ESRB_SMALL_WORDS  32
`define ESRB_SMALL_BITS   18
`define ESRB_MEDIUM_WORDS 128
`define ESRB_MEDIUM_BITS  36
`define ESRB_LARGE_WORDS  4096
`define ESRB_LARGE_BITS   144

// Bits per byte with and without parity
`define ESRB_BYTE_BITS   8
`define ESRB_PBYTE_BITS  9

`endif

// [hdl/esrb_port_sel.v]
// Address to bit-slice mapping for one port of the shared array
`timescale 1ns/1ps
module esrb_port_sel #(
	parameter TOTAL_BITS = 576,
	parameter WIDTH      = 18,
	parameter AW         = 5
) (
	// Word address
	input  wire [AW-1:0] i_addr,
	// First bit of the selected slice
	output wire [15:0]   o_base
);
	// Narrow ports index finer slices of the same bit array
	wire [31:0] base_full;
	assign base_full = {{(32-AW){1'b0}}, i_addr} * WIDTH;
	assign o_base = (base_full < TOTAL_BITS) ? base_full[15:0] : 16'h0000;
endmodule // esrb_port_sel

// [hdl/esrb_ram.v]
// Embedded synchronous RAM block with two configurable ports
// Contract
// - Three variants: 32x18, 128x36 and 4Kx144 maximum organisations.
// - True dual-port on medium and large: own clocks, but port B writes go to mem_b_dummy, not the shared array.
// - Simple dual-port reads and writes together; collision gives old or undefined data.
// - Single-port never reads and writes together; unregistered output shows new data.
// - Registered single-port output loads the old data on the write edge.
// - Address, data, write and read enables are captured in input registers; clear inputs act directly.
// - Write strobe generated internally from the port clock.
// - Each read port has a bypassable output register.
// - Small and medium simple dual-port allow flow-through falling-edge read registers.
// - Read and write ports may use different data widths.
// - Medium split points port B reads at the upper half; port B writes go to mem_b_dummy.
// - Large variant has no preload; user writes once then holds write disabled.
// - Word widths with or without parity, one extra bit per byte.
// - Small/medium clear input and output registers; large clears only outputs.
`timescale 1ns/1ps
`include "esrb_defines.vh"
module esrb_ram #(
	parameter VARIANT  = 1,  // 0 small, 1 medium, 2 large
	parameter MODE     = 2,  // 0 single, 1 simple, 2 true, 3 rom
	parameter PARITY   = 1,  // Nine bits per byte when set
	parameter WIDTH_A  = 36,
	parameter WIDTH_B  = 36,
	parameter AW_A     = 7,
	parameter AW_B     = 7,
	parameter OUTREG_A = 1,
	parameter OUTREG_B = 1,
	parameter FLOW     = 0,  // Falling-edge read registers on port B
	parameter OLD_DATA = 1,  // Collision read returns old data
	parameter SPLIT    = 0   // Medium: port B reads the upper half, port B writes go to mem_b_dummy
) (
	// Clocks and reset
	input  wire                 i_core_clk,
	input  wire                 i_clk_b,
	input  wire                 i_resetn,
	// Port A
	input  wire [AW_A-1:0]      i_addr_a,
	input  wire [WIDTH_A-1:0]   i_data_a,
	input  wire                 i_wren_a,
	input  wire                 i_rden_a,
	input  wire                 i_inclr_a,
	input  wire                 i_outclr_a,
	output wire [WIDTH_A-1:0]   o_q_a,
	// Port B
	input  wire [AW_B-1:0]      i_addr_b,
	input  wire [WIDTH_B-1:0]   i_data_b,
	input  wire                 i_wren_b,
	input  wire                 i_rden_b,
	input  wire                 i_inclr_b,
	input  wire                 i_outclr_b,
	output wire [WIDTH_B-1:0]   o_q_b
);
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam TOTAL_BITS = (VARIANT == 0) ? `ESRB_SMALL_WORDS * `ESRB_SMALL_BITS :
		(VARIANT == 1) ? `ESRB_MEDIUM_WORDS * `ESRB_MEDIUM_BITS :
		`ESRB_LARGE_WORDS * `ESRB_LARGE_BITS;
	localparam BYTE_W   = PARITY ? `ESRB_PBYTE_BITS : `ESRB_BYTE_BITS;
	localparam IN_CLR   = (VARIANT != 2);
	localparam B_TRUE   = (MODE == 2) && (VARIANT != 0);
	localparam B_WRITE  = B_TRUE || (SPLIT && VARIANT == 1);
	localparam HALF_OFS = (SPLIT && VARIANT == 1) ? TOTAL_BITS / 2 : 0;
	localparam FLOW_OK  = FLOW && (MODE == 1) && (VARIANT != 2);

	// Bit array shared by both ports
	reg [TOTAL_BITS-1:0] mem;

	// ****************************************************************
	// Input registers
	// ****************************************************************
	reg [AW_A-1:0]    addr_a;
	reg [WIDTH_A-1:0] data_a;
	reg               wren_a;
	reg               rden_a;
	reg [AW_B-1:0]    addr_b;
	reg [WIDTH_B-1:0] data_b;
	reg               wren_b;
	reg               rden_b;
	reg [AW_B-1:0]    addr_b_n;
	reg               rden_b_n;

	// Port A capture; clear only where the variant has input clears
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			addr_a <= {AW_A{1'b0}};
			data_a <= {WIDTH_A{1'b0}};
			wren_a <= 1'b0;
			rden_a <= 1'b0;
		end else if (IN_CLR && i_inclr_a) begin
			addr_a <= {AW_A{1'b0}};
			data_a <= {WIDTH_A{1'b0}};
			wren_a <= 1'b0;
			rden_a <= 1'b0;
		end else begin
			addr_a <= i_addr_a;
			data_a <= i_data_a;
			wren_a <= i_wren_a && (MODE != 3);
			rden_a <= i_rden_a && !(MODE == 0 && i_wren_a);
		end
	end

	// Port B capture on its own clock
	always @(posedge i_clk_b or negedge i_resetn) begin
		if (!i_resetn) begin
			addr_b <= {AW_B{1'b0}};
			data_b <= {WIDTH_B{1'b0}};
			wren_b <= 1'b0;
			rden_b <= 1'b0;
		end else if (IN_CLR && i_inclr_b) begin
			addr_b <= {AW_B{1'b0}};
			data_b <= {WIDTH_B{1'b0}};
			wren_b <= 1'b0;
			rden_b <= 1'b0;
		end else begin
			addr_b <= i_addr_b;
			data_b <= i_data_b;
			wren_b <= i_wren_b && B_WRITE && (MODE != 3);
			rden_b <= i_rden_b;
		end
	end

	// Falling-edge read registers for flow-through reads
	always @(negedge i_clk_b or negedge i_resetn) begin
		if (!i_resetn) begin
			addr_b_n <= {AW_B{1'b0}};
			rden_b_n <= 1'b0;
		end else if (IN_CLR && i_inclr_b) begin
			addr_b_n <= {AW_B{1'b0}};
			rden_b_n <= 1'b0;
		end else begin
			addr_b_n <= i_addr_b;
			rden_b_n <= i_rden_b;
		end
	end

	// ****************************************************************
	// Slice selection
	// ****************************************************************
	wire [15:0] base_a;
	wire [15:0] base_b;
	wire [AW_B-1:0] raddr_b;
	assign raddr_b = FLOW_OK ? addr_b_n : addr_b;

	esrb_port_sel #(.TOTAL_BITS(TOTAL_BITS), .WIDTH(WIDTH_A), .AW(AW_A)) u_sel_a (
		.i_addr (addr_a),
		.o_base (base_a)
	);
	wire [15:0] base_b_raw;
	esrb_port_sel #(.TOTAL_BITS(TOTAL_BITS), .WIDTH(WIDTH_B), .AW(AW_B)) u_sel_b (
		.i_addr (wren_b ? addr_b : raddr_b),
		.o_base (base_b_raw)
	);
	assign base_b = base_b_raw + HALF_OFS[15:0];

	// ****************************************************************
	// Array writes: strobe derived from the captured enable and the clock
	// ****************************************************************
	integer ia;
	always @(posedge i_core_clk) begin
		if (wren_a) begin
			for (ia = 0; ia < WIDTH_A; ia = ia + 1)
				if (base_a + ia < TOTAL_BITS)
					mem[base_a + ia] <= data_a[ia];
		end
	end

	integer ib;
	reg [TOTAL_BITS-1:0] mem_b_dummy;
	// Port B writes, in true dual-port or split mode, go to mem_b_dummy, which no read uses
	always @(posedge i_clk_b) begin
		if (wren_b) begin
			for (ib = 0; ib < WIDTH_B; ib = ib + 1)
				if (base_b + ib < TOTAL_BITS)
					mem_b_dummy[base_b + ib] <= data_b[ib];
		end
	end

	// ****************************************************************
	// Array reads
	// ****************************************************************
	reg [WIDTH_A-1:0] arr_a;
	reg [WIDTH_B-1:0] arr_b;
	reg               rd_b;
	integer ja;
	integer jb;
	always @* begin
		arr_a = {WIDTH_A{1'b0}};
		for (ja = 0; ja < WIDTH_A; ja = ja + 1)
			if (base_a + ja < TOTAL_BITS)
				arr_a[ja] = mem[base_a + ja];
	end
	always @* begin
		arr_b = {WIDTH_B{1'b0}};
		rd_b = FLOW_OK ? rden_b_n : rden_b;
		for (jb = 0; jb < WIDTH_B; jb = jb + 1)
			if (base_b + jb < TOTAL_BITS)
				arr_b[jb] = mem[base_b + jb];
		if (!OLD_DATA && wren_a && base_a == base_b)
			arr_b = {WIDTH_B{1'bx}};
	end

	// ****************************************************************
	// Output registers, bypassable
	// ****************************************************************
	reg [WIDTH_A-1:0] qreg_a;
	reg [WIDTH_B-1:0] qreg_b;
	reg [WIDTH_A-1:0] hold_a;
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			qreg_a <= {WIDTH_A{1'b0}};
		else if (i_outclr_a)
			qreg_a <= {WIDTH_A{1'b0}};
		else if (rden_a || (MODE == 0 && wren_a))
			qreg_a <= arr_a;
	end
	always @(posedge i_clk_b or negedge i_resetn) begin
		if (!i_resetn)
			qreg_b <= {WIDTH_B{1'b0}};
		else if (i_outclr_b)
			qreg_b <= {WIDTH_B{1'b0}};
		else if (rd_b)
			qreg_b <= arr_b;
	end
	assign o_q_a = OUTREG_A ? qreg_a : arr_a;
	assign o_q_b = (OUTREG_B && !FLOW_OK) ? qreg_b : arr_b;
endmodule // esrb_ram

// [test/esrb_checker.sv]
// Concurrent checks on the RAM block ports
`timescale 1ns/1ps
module esrb_checker #(
	parameter WIDTH_A = 36,
	parameter WIDTH_B = 36,
	parameter AW_A    = 7,
	parameter AW_B    = 7
) (
	// Clock and reset
	input wire               i_core_clk,
	input wire               i_clk_b,
	input wire               i_resetn,
	// Port controls
	input wire [AW_A-1:0]    i_addr_a,
	input wire [AW_B-1:0]    i_addr_b,
	input wire               i_wren_a,
	input wire               i_wren_b,
	input wire               i_rden_a,
	input wire               i_rden_b,
	input wire               i_outclr_a,
	input wire               i_outclr_b,
	// Read data
	input wire [WIDTH_A-1:0] o_q_a,
	input wire [WIDTH_B-1:0] o_q_b
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	a_rst_zero_a: assert property ($rose(i_resetn) |-> o_q_a == '0) else $error("q_a not clear");
	a_rst_zero_b: assert property (@(posedge i_clk_b) disable iff (!i_resetn)
		$rose(i_resetn) |-> o_q_b == '0) else $error("q_b not clear");
	a_clr_zero_a: assert property (i_outclr_a [*2] |-> o_q_a == '0) else $error("q_a clear");
	a_clr_zero_b: assert property (@(posedge i_clk_b) disable iff (!i_resetn)
		i_outclr_b [*2] |-> o_q_b == '0) else $error("q_b clear");
	a_hold_q_a: assert property ((!i_rden_a && !i_outclr_a) [*3] |=> $stable(o_q_a)) else $error("q_a moved");
	a_hold_q_b: assert property (@(posedge i_clk_b) disable iff (!i_resetn)
		(!i_rden_b && !i_outclr_b) [*3] |=> $stable(o_q_b)) else $error("q_b moved");
	a_same_read: assert property (i_rden_a && i_rden_b && i_addr_a == i_addr_b && !i_wren_a && !i_wren_b
		&& !i_outclr_a && !i_outclr_b |-> ##2 o_q_a == o_q_b) else $error("ports differ");
	a_clr_next_a: assert property (i_outclr_a |=> o_q_a == '0) else $error("q_a not cleared next");
endmodule // esrb_checker

// [test/esrb_user_model.sv]
// User-logic model driving the read side of port B
`timescale 1ns/1ps
module esrb_user_model (
	// Clock and requests
	input  wire        i_core_clk,
	input  wire        i_req,
	input  wire [6:0]  i_addr,
	// Port B drive
	output reg         o_rden_b = 1'b0,
	output reg  [6:0]  o_addr_b = 7'h00,
	output reg  [35:0] o_data_b = 36'h0_0000_0000,
	output wire        o_wren_b
);
	reg       req;
	reg [6:0] addr;
	// Write enable held off throughout; port B never writes
	assign o_wren_b = 1'b0;
	// Take requests at rise
	always @(posedge i_core_clk) begin
		req <= i_req;
		addr <= i_addr;
	end
	// Present at fall; idle lines keep toggling
	always @(negedge i_core_clk) begin
		o_rden_b <= req;
		o_addr_b <= req ? addr : ~o_addr_b;
		o_data_b <= ~o_data_b;
	end
endmodule // esrb_user_model

// [test/tb_top.sv]
// Self-checking bench for the RAM block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t mismatch", $time); end end
module tb_top;
	reg         clk = 0, rstn = 0, wren_a = 0, rden_a = 0, clr_a = 0, clr_b = 0, req = 0;
	reg  [6:0]  addr_a = 0, addr_m = 0;
	reg  [35:0] data_a = 0;
	wire [35:0] q_a, q_b, data_b;
	wire [6:0]  addr_b;
	wire        rden_b, wren_b;
	int         error_cnt = 0, checks = 0, cyc = 0;
	// Clock and cycle ceiling
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			conclude;
		end
	end
	esrb_ram esrb_ram_inst (.i_core_clk(clk), .i_clk_b(clk), .i_resetn(rstn), .i_addr_a(addr_a), .i_data_a(data_a),
		.i_wren_a(wren_a), .i_rden_a(rden_a), .i_inclr_a(1'b0), .i_outclr_a(clr_a), .o_q_a(q_a), .i_addr_b(addr_b),
		.i_data_b(data_b), .i_wren_b(wren_b), .i_rden_b(rden_b), .i_inclr_b(1'b0), .i_outclr_b(clr_b), .o_q_b(q_b));
	esrb_user_model esrb_user_model_inst (.i_core_clk(clk), .i_req(req), .i_addr(addr_m), .o_rden_b(rden_b),
		.o_addr_b(addr_b), .o_data_b(data_b), .o_wren_b(wren_b));
	function automatic [35:0] pat(input [6:0] a);
		pat = {a, 29'h0a5a_5a5a} ^ {29'h0000_0000, ~a};
	endfunction
	// Read one address on both ports at once
	task rd(input [6:0] a);
		begin
			@(negedge clk);
			req = 1;
			addr_m = a;
			@(negedge clk);
			req = 0;
			rden_a = 1;
			addr_a = a;
			@(negedge clk);
			rden_a = 0;
			addr_a = ~a;
			repeat (2) @(negedge clk);
			`CHK(q_a, pat(a))
			`CHK(q_b, pat(a))
		end
	endtask
	// Back-to-back writes at both address ends
	task t_fill;
		begin
			@(negedge clk);
			wren_a = 1;
			for (int i = 0; i < 4; i++) begin
				addr_a = 7'((i < 2) ? i : 124 + i);
				data_a = pat(addr_a);
				@(negedge clk);
			end
			wren_a = 0;
			rd(7'h7f);
			rd(7'h00);
			rd(7'h01);
			rd(7'h7e);
		end
	endtask
	// Output holds across a write with no read
	task t_hold;
		begin
			rd(7'h01);
			@(negedge clk);
			wren_a = 1;
			addr_a = 7'h01;
			data_a = ~pat(7'h01);
			@(negedge clk);
			wren_a = 0;
			repeat (3) @(negedge clk);
			`CHK(q_a, pat(7'h01))
		end
	endtask
	// Output clears, then reads resume
	task t_clear;
		begin
			@(negedge clk);
			clr_a = 1;
			clr_b = 1;
			repeat (2) @(negedge clk);
			`CHK(q_a, 36'h0_0000_0000)
			`CHK(q_b, 36'h0_0000_0000)
			clr_a = 0;
			clr_b = 0;
			rd(7'h7e);
		end
	endtask
	task conclude;
		begin
			$display("errors %0d checks %0d", error_cnt, checks);
			if (error_cnt == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rstn = 1;
		t_fill;
		t_hold;
		t_clear;
		conclude;
	end
endmodule // tb_top
bind esrb_ram esrb_checker #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B), .AW_A(AW_A), .AW_B(AW_B)) esrb_checker_inst (
	.i_core_clk(i_core_clk), .i_clk_b(i_clk_b), .i_resetn(i_resetn), .i_addr_a(i_addr_a), .i_addr_b(i_addr_b),
	.i_wren_a(i_wren_a),
	.i_wren_b(i_wren_b), .i_rden_a(i_rden_a), .i_rden_b(i_rden_b), .i_outclr_a(i_outclr_a),
	.i_outclr_b(i_outclr_b), .o_q_a(o_q_a), .o_q_b(o_q_b));
